// ===== include/opsc_pkg.sv
/*
 Constants and types of the oscillator and PLL startup control.
 Assumes a 200 MHz system clock and 32-bit classic Wishbone access.
*/
package opsc_pkg;
   localparam longint unsigned CLK_FREQ_HZ = 200_000_000;
   localparam longint unsigned XTAL_DLY_MS = 1200;
   localparam longint unsigned RC_DLY_US   = 200;
   // Least times, so round up
   localparam longint unsigned XTAL_DLY_CYC = (XTAL_DLY_MS * CLK_FREQ_HZ + 64'd999) / 64'd1000;
   localparam longint unsigned RC_DLY_CYC   = (RC_DLY_US * CLK_FREQ_HZ + 64'd999_999) / 64'd1_000_000;
   localparam int SLOW_DLY_W = 28;

   // Register offsets (byte addresses)
   localparam logic [7:0] MAIN_OSC_CONTROL_OFS = 8'h00;
   localparam logic [7:0] FREQ_MEASURE_OFS     = 8'h04;
   localparam logic [7:0] PLL_A_CONFIG_OFS     = 8'h08;
   localparam logic [7:0] PLL_B_CONFIG_OFS     = 8'h0C;
   localparam logic [7:0] POWER_STATUS_OFS     = 8'h10;
   localparam logic [7:0] POWER_IRQ_MASK_OFS   = 8'h14;

   // Field positions and widths
   localparam int OSC_EN_BIT     = 0;
   localparam int OSC_BYPASS_BIT = 1;
   localparam int OSC_COUNT_LSB  = 8;
   localparam int OSC_COUNT_W    = 8;
   localparam int FREQ_W         = 16;
   localparam int FREQ_DONE_BIT  = 16;
   localparam int STAT_STABLE_BIT = 0;
   localparam int STAT_LOCK_LSB   = 1;
   localparam int STAT_SLOW_BIT   = 3;
   localparam int IRQ_W           = 3;
   localparam int PLL_NUM         = 2;

   // Counting constants
   localparam logic [2:0] OSC_PRESCALE_LAST = 3'h7;
   localparam logic [3:0] FREQ_LAST_FALL    = 4'hF;

   // Reset values and PLL config write mask
   localparam logic [31:0] PLL_CFG_RESET  = 32'h0000_0000;
   localparam logic [31:0] PLL_CFG_MASK   = 32'h07FF_3FFF;
   localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

   typedef struct packed {
      logic [4:0]  rsvd_hi;
      logic [10:0] pll_multiplier;
      logic [1:0]  rsvd_mid;
      logic [5:0]  pll_settle_count;
      logic [7:0]  div;
   } opsc_pll_cfg_type;

   typedef enum logic [1:0] {MEAS_IDLE, MEAS_ARM, MEAS_RUN, MEAS_DONE} opsc_meas_type;
endpackage

// ===== sim/opsc_osc_model.sv
/*
 Behavioural model of the analogue side: slow clock source and main oscillator.
 Assumes clk_i is the 200 MHz system clock; both clocks are produced as levels
 sampled against it, each far slower than clk_i.
*/
`timescale 1ns/1ps
module opsc_osc_model #(
   parameter int SLOW_HALF = 20,                  // Slow clock half period in clk_i cycles
   parameter int MAIN_HALF = 5                    // Main clock half period in clk_i cycles
) (
   input  wire logic clk_i,                       // System clock
   input  wire logic main_osc_enable_i,           // Oscillator enable from the block
   input  wire logic main_osc_bypass_i,           // External clock on the input pin
   output logic      slow_clk_o,                  // Slow clock
   output logic      main_clk_o                   // Main clock, low while stopped
);
   int s_cnt;
   int m_cnt;

   initial begin
      s_cnt      = 0;
      slow_clk_o = 1'b0;
      m_cnt      = 0;
      main_clk_o = 1'b0;
   end

   // Slow clock never stops, so every countdown keeps moving
   always @(posedge clk_i) begin
      s_cnt <= (s_cnt == SLOW_HALF - 1) ? 0 : s_cnt + 1;
      if (s_cnt == SLOW_HALF - 1) slow_clk_o <= ~slow_clk_o;
   end

   // A stopped oscillator gives a flat low line, not a held last phase
   always @(posedge clk_i) begin
      if (main_osc_enable_i || main_osc_bypass_i) begin
         m_cnt <= (m_cnt == MAIN_HALF - 1) ? 0 : m_cnt + 1;
         if (m_cnt == MAIN_HALF - 1) main_clk_o <= ~main_clk_o;
      end else begin
         m_cnt      <= 0;
         main_clk_o <= 1'b0;
      end
   end
endmodule

// ===== sim/tb_osc_pll_startup_control.sv
/*
 Testbench of the clock generator control: Wishbone tasks and register scenarios.
 Assumes the oscillator model drives slow and main clocks; short slow delays.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_osc_pll_startup_control;
   import opsc_pkg::*;
   localparam logic [SLOW_DLY_W-1:0] XD = 28'h14;   // Crystal delay, 20 cycles
   localparam logic [SLOW_DLY_W-1:0] RD = 28'h0A;   // RC delay, 10 cycles

   logic                             clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i;
   logic [7:0]                       wb_adr_i;
   logic [31:0]                      wb_dat_i, wb_dat_o, q, m;
   logic [3:0]                       wb_sel_i;
   logic                             wb_ack_o, slow_clk_i, main_clk_i, slow_source_select_i;
   logic                             slow_clk_ready_o, main_osc_enable_o, main_osc_bypass_o, irq_o;
   opsc_pll_cfg_type [PLL_NUM-1:0]   pll_cfg_o;
   logic [PLL_NUM-1:0]               pll_run_o;
   int                               err_count, n_tests, p;
   logic [31:0]                      cfg;

   opsc_clock_gen_ctrl #(.XTAL_DLY(XD), .RC_DLY(RD)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .slow_clk_i(slow_clk_i), .main_clk_i(main_clk_i),
      .slow_source_select_i(slow_source_select_i), .slow_clk_ready_o(slow_clk_ready_o),
      .main_osc_enable_o(main_osc_enable_o), .main_osc_bypass_o(main_osc_bypass_o),
      .pll_cfg_o(pll_cfg_o), .pll_run_o(pll_run_o), .irq_o(irq_o));

   // Slow period 40 cycles, main period 10 cycles: 16 slow periods hold 64 main cycles
   opsc_osc_model #(.SLOW_HALF(20), .MAIN_HALF(5)) osc (
      .clk_i(clk_i), .main_osc_enable_i(main_osc_enable_o), .main_osc_bypass_i(main_osc_bypass_o),
      .slow_clk_o(slow_clk_i), .main_clk_o(main_clk_i));

   // Clock generation
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Verdict and end of run
   task automatic summarize();
      if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Classic single cycle; ack is waited for, never assumed
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         err_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
         summarize();
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      `CHK(r, e)
   endtask

   // Poll one bit under a bounded count of reads
   task automatic wt(input logic [7:0] a, input int b, input logic v, input int lim);
      logic [31:0] r;
      int          n;
      n = 0;
      do begin
         wb(1'b0, a, 32'h0, r);
         n++;
      end while (r[b] !== v && n < lim);
      `CHK(r[b], v)
   endtask

   task automatic do_reset(input logic s);
      @(posedge clk_i);
      slow_source_select_i <= s;
      rst_i                <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_i);
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
      summarize();
   end

   // Main sequence
   initial begin
      err_count = 0;
      n_tests   = 0;
      {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, slow_source_select_i} = 5'h10;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'h0;
      // Slow delay depends on the source select level
      do_reset(1'b0);
      repeat (8) @(posedge clk_i);
      `CHK(slow_clk_ready_o, 1'b0)
      repeat (5) @(posedge clk_i);
      `CHK(slow_clk_ready_o, 1'b1)
      do_reset(1'b1);
      repeat (13) @(posedge clk_i);
      `CHK(slow_clk_ready_o, 1'b0)
      repeat (12) @(posedge clk_i);
      `CHK(slow_clk_ready_o, 1'b1)
      // Reset values, including the unmapped place at 0x18
      for (int i = 0; i < 7; i++) rc(8'(i * 4), (i == 4) ? 32'h0000_0008 : 32'h0);
      `CHK(main_osc_enable_o, 1'b0)
      `CHK(pll_run_o, 2'h0)
      // Startup count 2 takes 16 slow rises, so no flag at 300 cycles
      wb(1'b1, MAIN_OSC_CONTROL_OFS, 32'hFFFF_0201, q);
      `CHK(main_osc_enable_o, 1'b1)
      rc(MAIN_OSC_CONTROL_OFS, 32'h0000_0201);
      repeat (300) @(posedge clk_i);
      rc(POWER_STATUS_OFS, 32'h0000_0008);
      wt(POWER_STATUS_OFS, STAT_STABLE_BIT, 1'b1, 400);
      // Frequency measurement over 15.5 slow periods
      wt(FREQ_MEASURE_OFS, FREQ_DONE_BIT, 1'b1, 1000);
      wb(1'b0, FREQ_MEASURE_OFS, 32'h0, m);
      `CHK(m[15:0] >= 16'h3D && m[15:0] <= 16'h41, 1'b1)
      repeat (200) @(posedge clk_i);
      rc(FREQ_MEASURE_OFS, m);
      // Interrupt follows stable flag through the mask
      wb(1'b1, POWER_IRQ_MASK_OFS, 32'h1, q);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      wb(1'b1, POWER_IRQ_MASK_OFS, 32'h0, q);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      // Bypass mode with the oscillator off drops the stable flag
      wb(1'b1, POWER_IRQ_MASK_OFS, 32'h1, q);
      wb(1'b1, MAIN_OSC_CONTROL_OFS, 32'h0000_0002, q);
      rc(POWER_STATUS_OFS, 32'h0000_0008);
      `CHK({main_osc_bypass_o, main_osc_enable_o}, 2'h2)
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      // Both PLLs: boundary divider, lock countdown, disable, zero divider
      for (p = 0; p < PLL_NUM; p++) begin
         cfg = 32'h0007_03FF;
         wb(1'b1, PLL_A_CONFIG_OFS + 8'(p * 4), 32'hF807_C3FF, q);
         rc(PLL_A_CONFIG_OFS + 8'(p * 4), cfg);
         `CHK(pll_cfg_o[p], cfg)
         rc(POWER_STATUS_OFS, 32'h0000_0008);
         wt(POWER_STATUS_OFS, STAT_LOCK_LSB + p, 1'b1, 100);
         `CHK(pll_run_o[p], 1'b1)
         wb(1'b1, POWER_IRQ_MASK_OFS, 32'(2 << p), q);
         repeat (2) @(posedge clk_i);
         `CHK(irq_o, 1'b1)
         wb(1'b1, PLL_A_CONFIG_OFS + 8'(p * 4), 32'h0000_03FF, q);
         repeat (200) @(posedge clk_i);
         wt(POWER_STATUS_OFS, STAT_LOCK_LSB + p, 1'b0, 1);
         `CHK(pll_run_o[p], 1'b0)
         wb(1'b1, PLL_A_CONFIG_OFS + 8'(p * 4), 32'h0007_0300, q);
         repeat (2) @(posedge clk_i);
         `CHK(pll_run_o[p], 1'b0)
         wb(1'b1, POWER_IRQ_MASK_OFS, 32'h0, q);
      end
      summarize();
   end
endmodule

// ===== verilog/opsc_clock_gen_ctrl.sv
/*
 Control logic of the clock generator: slow clock delay, main oscillator
 startup and frequency measurement, two PLL lock countdowns, Wishbone regs.
 Assumes slow_clk_i and main_clk_i are sampled synchronously to clk_i,
 with each clock far slower than clk_i.
*/
`timescale 1ns/1ps
module opsc_clock_gen_ctrl #(
   parameter logic [opsc_pkg::SLOW_DLY_W-1:0] XTAL_DLY = opsc_pkg::SLOW_DLY_W'(opsc_pkg::XTAL_DLY_CYC),
   parameter logic [opsc_pkg::SLOW_DLY_W-1:0] RC_DLY   = opsc_pkg::SLOW_DLY_W'(opsc_pkg::RC_DLY_CYC)
) (
   input  wire logic                                           clk_i,                // System clock
   input  wire logic                                           rst_i,                // Sync reset
   input  wire logic [7:0]                                     wb_adr_i,             // Byte address
   input  wire logic [31:0]                                    wb_dat_i,             // Write data
   input  wire logic [3:0]                                     wb_sel_i,             // Byte enables
   input  wire logic                                           wb_we_i,              // Write
   input  wire logic                                           wb_cyc_i,             // Cycle
   input  wire logic                                           wb_stb_i,             // Strobe
   output logic      [31:0]                                    wb_dat_o,             // Read data
   output logic                                                wb_ack_o,             // Acknowledge
   input  wire logic                                           slow_clk_i,           // Slow clock, sampled
   input  wire logic                                           main_clk_i,           // Main clock, sampled
   input  wire logic                                           slow_source_select_i, // 1 crystal, 0 RC
   output logic                                                slow_clk_ready_o,     // Slow startup done
   output logic                                                main_osc_enable_o,    // Oscillator enable
   output logic                                                main_osc_bypass_o,    // Oscillator bypass
   output wire opsc_pkg::opsc_pll_cfg_type [opsc_pkg::PLL_NUM-1:0] pll_cfg_o,       // PLL settings
   output wire logic [opsc_pkg::PLL_NUM-1:0]                   pll_run_o,            // PLL powered, output on
   output logic                                                irq_o                 // Interrupt
);
   import opsc_pkg::*;
   // Every assertion runs on the system clock and sleeps while reset is high
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Byte-lane merge of a write into a register's old value
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Word address match
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      return adr[7:2] == ofs[7:2];
   endfunction

   logic                   wb_req;
   logic                   wr_mor;
   logic                   wr_mask;
   logic [PLL_NUM-1:0]     wr_pll;
   logic [31:0]            mor_rd;
   logic [31:0]            mor_new;
   logic [31:0]            rd_mux;
   logic                   slow_d_q;
   logic                   main_d_q;
   logic                   slow_rise;
   logic                   slow_fall;
   logic                   main_rise;
   logic [SLOW_DLY_W-1:0]  slow_dly_q;
   logic [SLOW_DLY_W-1:0]  slow_limit;
   logic [OSC_COUNT_W-1:0] osc_count_q;
   logic [OSC_COUNT_W-1:0] osc_cnt_q;
   logic [2:0]             prescale_q;
   logic                   osc_busy_q;
   logic                   stable_q;
   opsc_meas_type          meas_q;
   logic [FREQ_W-1:0]      freq_cnt_q;
   logic [3:0]             fall_cnt_q;
   logic                   done_q;
   opsc_pll_cfg_type       cfg_q [PLL_NUM];
   opsc_pll_cfg_type       cfg_new [PLL_NUM];
   logic [5:0]             pll_cnt_q [PLL_NUM];
   logic [PLL_NUM-1:0]     pll_busy_q;
   logic [PLL_NUM-1:0]     lock_q;
   logic [PLL_NUM-1:0]     run_q;
   logic [IRQ_W-1:0]       mask_q;
   logic [IRQ_W-1:0]       stat;

   // One request is taken per ack; the ack cycle itself is not a new request
   assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_mor  = wb_req & wb_we_i & hit(wb_adr_i, MAIN_OSC_CONTROL_OFS);
   assign wr_mask = wb_req & wb_we_i & hit(wb_adr_i, POWER_IRQ_MASK_OFS);
   assign wr_pll  = {PLL_NUM{wb_req & wb_we_i}} &
                    {hit(wb_adr_i, PLL_B_CONFIG_OFS), hit(wb_adr_i, PLL_A_CONFIG_OFS)};
   assign mor_rd  = {16'h0000, osc_count_q, 6'h00, main_osc_bypass_o, main_osc_enable_o};
   assign mor_new = merge_sel(mor_rd, wb_dat_i, wb_sel_i);
   assign stat    = {lock_q, stable_q};

   // Read multiplexer; unmapped words read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(wb_adr_i, MAIN_OSC_CONTROL_OFS)) begin
         rd_mux = mor_rd;
      end else if (hit(wb_adr_i, FREQ_MEASURE_OFS)) begin
         rd_mux = {15'h0000, done_q, freq_cnt_q};
      end else if (hit(wb_adr_i, PLL_A_CONFIG_OFS)) begin
         rd_mux = cfg_q[0];
      end else if (hit(wb_adr_i, PLL_B_CONFIG_OFS)) begin
         rd_mux = cfg_q[1];
      end else if (hit(wb_adr_i, POWER_STATUS_OFS)) begin
         rd_mux = {28'h0000000, slow_clk_ready_o, stat};
      end else if (hit(wb_adr_i, POWER_IRQ_MASK_OFS)) begin
         rd_mux = {29'h00000000, mask_q};
      end
   end

   // Bus answer one cycle after the request, every address acknowledged
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   // Edge detection; reset loads the pin level so no false edge follows release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slow_d_q <= slow_clk_i;
         main_d_q <= main_clk_i;
      end else begin
         slow_d_q <= slow_clk_i;
         main_d_q <= main_clk_i;
      end
   end
   assign slow_rise = slow_clk_i & ~slow_d_q;
   assign slow_fall = ~slow_clk_i & slow_d_q;
   assign main_rise = main_clk_i & ~main_d_q;

   // Slow clock startup delay; select is read live after release, so a strap settles first
   assign slow_limit = slow_source_select_i ? XTAL_DLY : RC_DLY;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slow_dly_q       <= '0;
         slow_clk_ready_o <= 1'b0;
      end else if (!slow_clk_ready_o) begin
         if (slow_dly_q >= slow_limit - 1'b1) begin
            slow_clk_ready_o <= 1'b1;
         end else begin
            slow_dly_q <= slow_dly_q + 1'b1;
         end
      end
   end

   // Main oscillator control register; off after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         main_osc_enable_o <= 1'b0;
         main_osc_bypass_o <= 1'b0;
         osc_count_q       <= '0;
      end else if (wr_mor) begin
         main_osc_enable_o <= mor_new[OSC_EN_BIT];
         main_osc_bypass_o <= mor_new[OSC_BYPASS_BIT];
         osc_count_q       <= mor_new[OSC_COUNT_LSB +: OSC_COUNT_W];
      end
   end

   // Startup countdown at slow/8; a write with the enable set restarts it even if it was about to finish
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_busy_q <= 1'b0;
         osc_cnt_q  <= '0;
         prescale_q <= 3'h0;
         stable_q   <= 1'b0;
      end else if (wr_mor) begin
         stable_q   <= 1'b0;
         osc_busy_q <= mor_new[OSC_EN_BIT];
         osc_cnt_q  <= mor_new[OSC_COUNT_LSB +: OSC_COUNT_W];
         prescale_q <= 3'h0;
      end else if (osc_busy_q) begin
         if (osc_cnt_q == '0) begin
            stable_q   <= 1'b1;
            osc_busy_q <= 1'b0;
         end else if (slow_rise) begin
            prescale_q <= prescale_q + 3'h1;
            if (prescale_q == OSC_PRESCALE_LAST) begin
               osc_cnt_q <= osc_cnt_q - 1'b1;
            end
         end
      end
   end

   // Frequency measurement; restarts each time the oscillator becomes stable
   always_ff @(posedge clk_i) begin
      if (rst_i || !stable_q) begin
         meas_q     <= MEAS_IDLE;
         freq_cnt_q <= '0;
         fall_cnt_q <= 4'h0;
         done_q     <= 1'b0;
      end else begin
         unique case (meas_q)
            MEAS_IDLE: begin
               meas_q <= MEAS_ARM;
            end
            MEAS_ARM: begin
               if (slow_rise) begin
                  meas_q <= MEAS_RUN;
               end
            end
            MEAS_RUN: begin
               if (main_rise) begin
                  freq_cnt_q <= freq_cnt_q + 1'b1;
               end
               if (slow_fall) begin
                  fall_cnt_q <= fall_cnt_q + 4'h1;
                  if (fall_cnt_q == FREQ_LAST_FALL) begin
                     done_q <= 1'b1;
                     meas_q <= MEAS_DONE;
                  end
               end
            end
            MEAS_DONE: begin
               meas_q <= MEAS_DONE;
            end
         endcase
      end
   end

   // Per PLL: configuration, lock countdown and run gate
   for (genvar g = 0; g < PLL_NUM; g++) begin : g_pll
      assign cfg_new[g]   = opsc_pll_cfg_type'(merge_sel(cfg_q[g], wb_dat_i, wb_sel_i) & PLL_CFG_MASK);
      assign pll_cfg_o[g] = cfg_q[g];
      assign pll_run_o[g] = run_q[g];

      // Only a real change restarts the lock wait
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cfg_q[g]      <= opsc_pll_cfg_type'(PLL_CFG_RESET);
            pll_cnt_q[g]  <= 6'h00;
            pll_busy_q[g] <= 1'b0;
            lock_q[g]     <= 1'b0;
         end else if (wr_pll[g] && cfg_new[g] != cfg_q[g]) begin
            cfg_q[g]      <= cfg_new[g];
            lock_q[g]     <= 1'b0;
            pll_cnt_q[g]  <= cfg_new[g].pll_settle_count;
            pll_busy_q[g] <= cfg_new[g].pll_multiplier != '0;
         end else if (pll_busy_q[g]) begin
            if (pll_cnt_q[g] == 6'h00) begin
               lock_q[g]     <= 1'b1;
               pll_busy_q[g] <= 1'b0;
            end else if (slow_rise) begin
               pll_cnt_q[g] <= pll_cnt_q[g] - 6'h01;
            end
         end
      end

      // Output held low while divider or multiplier is zero
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            run_q[g] <= 1'b0;
         end else begin
            run_q[g] <= cfg_q[g].div != '0 && cfg_q[g].pll_multiplier != '0;
         end
      end

      a_pll_restart : assert property (wr_pll[g] && cfg_new[g] != cfg_q[g] |=>
         !lock_q[g] && pll_cnt_q[g] == $past(cfg_new[g].pll_settle_count)) else $error("pll restart");
      a_pll_lock_set : assert property (pll_busy_q[g] && pll_cnt_q[g] == 6'h00 && !wr_pll[g] |=> lock_q[g])
         else $error("pll lock not set");
      a_pll_div_zero : assert property (cfg_q[g].div == '0 |=> !pll_run_o[g])
         else $error("pll output with zero divider");
   end

   // Interrupt mask and output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= IRQ_MASK_RESET;
         irq_o  <= 1'b0;
      end else begin
         if (wr_mask) begin
            mask_q <= IRQ_W'(merge_sel({29'h00000000, mask_q}, wb_dat_i, wb_sel_i));
         end
         irq_o <= |(stat & mask_q);
      end
   end

   sequence s_osc_start;
      wr_mor && mor_new[OSC_EN_BIT];
   endsequence
   sequence s_osc_armed;
      !stable_q && osc_busy_q;
   endsequence

   a_reset_osc_off : assert property ($fell(rst_i) |-> !main_osc_enable_o && !stable_q && pll_run_o == '0 &&
      cfg_q[0].div == '0 && cfg_q[1].div == '0) else $error("state after reset");
   a_osc_start : assert property (s_osc_start |=> s_osc_armed ##0 osc_cnt_q == $past(mor_new[15:8]))
      else $error("oscillator start");
   a_osc_off : assert property (wr_mor && !mor_new[OSC_EN_BIT] |=> !stable_q [*2])
      else $error("stable flag after disable");
   a_osc_prescale : assert property (osc_busy_q && !wr_mor && !(slow_rise && prescale_q == OSC_PRESCALE_LAST)
      |=> $stable(osc_cnt_q)) else $error("countdown not divided by 8");
   a_osc_stable : assert property (osc_busy_q && osc_cnt_q == '0 && !wr_mor |=> stable_q)
      else $error("stable flag not set");
   a_meas_done : assert property (meas_q == MEAS_RUN && slow_fall && fall_cnt_q == FREQ_LAST_FALL
      && stable_q && !wr_mor |=> done_q && meas_q == MEAS_DONE) else $error("measurement not done");
   a_meas_frozen : assert property (done_q && stable_q && !wr_mor |=> $stable(freq_cnt_q))
      else $error("count moved after done");
   a_meas_wait : assert property (meas_q == MEAS_ARM && !slow_rise && stable_q && !wr_mor |=> freq_cnt_q == '0)
      else $error("count started early");
   a_irq_follow : assert property (##1 irq_o == |($past(stat & mask_q)))
      else $error("interrupt mismatch");
   a_slow_ready : assert property ($rose(slow_clk_ready_o) |-> $past(slow_dly_q) >= $past(slow_limit) - 1'b1)
      else $error("slow clock ready early");
endmodule
